// ---- ext_irq_latch.sv ----
// external interrupt latch with ahb-lite register slave
`timescale 1ns/1ps
`include "ext_irq_consts.svh"
module ext_irq_latch
   import ext_irq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        irq_pin_n,
   input  wire logic        vector_fetch,
   input  wire logic        break_state,
   input  wire logic        low_power,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             cpu_request,
   output logic             wake_request,
   output logic [15:0]      vector_addr,
   output logic             branch_if_pin_high,
   output logic             branch_if_pin_low,
   output logic             irq
);
   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   logic pin_level;
   logic pin_fall;

   pin_sync u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin_n   (irq_pin_n),
      .level_q (pin_level),
      .fall_q  (pin_fall)
   );

   // ------------------------------------------------------------
   // bus address phase capture
   // ------------------------------------------------------------
   bus_phase_t  phase_q;
   logic [11:0] addr_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_q <= BUS_IDLE;
         addr_q  <= 12'h000;
      end else if (hready) begin
         if (hsel && htrans[1]) begin
            phase_q <= hwrite ? BUS_WRITE : BUS_READ;
            addr_q  <= haddr[11:0];
         end else begin
            phase_q <= BUS_IDLE;
         end
      end
   end

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] r);
      hit = (a[11:2] == r[11:2]);
   endfunction : hit

   logic wr;
   assign wr = (phase_q == BUS_WRITE);

   // ------------------------------------------------------------
   // control bits
   // ------------------------------------------------------------
   logic ext_request_mask_q;
   logic level_sense_select_q;
   logic break_clear_enable_q;
   logic [1:0] int_mask_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_request_mask_q   <= 1'b0;
         level_sense_select_q <= 1'b0;
         break_clear_enable_q <= 1'b0;
         int_mask_q           <= 2'h0;
      end else if (wr) begin
         if (hit(addr_q, `ADDR_STATUS_CONTROL)) begin
            ext_request_mask_q   <= hwdata[`BIT_MASK];
            level_sense_select_q <= hwdata[`BIT_LEVEL_SEL];
         end else if (hit(addr_q, `ADDR_IRQ_MASK)) begin
            int_mask_q <= hwdata[1:0];
         end else if (hit(addr_q, `ADDR_BREAK_CTRL)) begin
            break_clear_enable_q <= hwdata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // request latch
   // ------------------------------------------------------------
   logic latch_clear_strobe;
   logic ack_pending_q;
   logic req_latch_q;
   logic ack_now;

   // break blocks software clears unless enabled
   assign latch_clear_strobe = wr && hit(addr_q, `ADDR_STATUS_CONTROL)
      && hwdata[`BIT_CLEAR]
      && (!break_state || break_clear_enable_q);
   assign ack_now = latch_clear_strobe || vector_fetch;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_latch_q   <= 1'b0;
         ack_pending_q <= 1'b0;
      end else if (pin_fall) begin
         // new edge wins over a same-cycle clear
         req_latch_q   <= 1'b1;
         ack_pending_q <= 1'b0;
      end else if (level_sense_select_q) begin
         // both acknowledge and pin high, either order
         if ((ack_now || ack_pending_q) && pin_level) begin
            req_latch_q   <= 1'b0;
            ack_pending_q <= 1'b0;
         end else if (ack_now && req_latch_q) begin
            ack_pending_q <= 1'b1;
         end
      end else if (ack_now) begin
         req_latch_q   <= 1'b0;
         ack_pending_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // cpu-facing outputs
   // ------------------------------------------------------------
   logic live_req;
   assign live_req = req_latch_q && !ext_request_mask_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_request        <= 1'b0;
         wake_request       <= 1'b0;
         vector_addr        <= `VECTOR_HIGH;
         branch_if_pin_high <= 1'b1;
         branch_if_pin_low  <= 1'b0;
      end else begin
         cpu_request        <= live_req;
         wake_request       <= live_req && low_power;
         vector_addr        <= `VECTOR_HIGH;
         branch_if_pin_high <= pin_level;
         branch_if_pin_low  <= !pin_level;
      end
   end

   // ------------------------------------------------------------
   // event status for system interrupt line
   // ------------------------------------------------------------
   logic [1:0] int_status_q;
   logic [1:0] w1c;

   assign w1c = (wr && hit(addr_q, `ADDR_IRQ_STATUS)) ?
                hwdata[1:0] : 2'h0;

   // bit0: falling edge seen, bit1: request reached cpu
   always_ff @(posedge clk_sys) begin
      if (rst) int_status_q <= 2'h0;
      else     int_status_q <= (int_status_q & ~w1c)
                              | {live_req, pin_fall};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) irq <= 1'b0;
      else     irq <= |(int_status_q & int_mask_q);
   end

   // ------------------------------------------------------------
   // read data and response
   // ------------------------------------------------------------
   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      if (phase_q == BUS_READ || (hready && hsel && htrans[1])) begin
         if (hit(haddr[11:0], `ADDR_STATUS_CONTROL)) begin
            rd_d[`BIT_EVENT_FLAG] = req_latch_q;
            rd_d[`BIT_CLEAR]      = 1'b0;
            rd_d[`BIT_MASK]       = ext_request_mask_q;
            rd_d[`BIT_LEVEL_SEL]  = level_sense_select_q;
         end else if (hit(haddr[11:0], `ADDR_IRQ_STATUS)) begin
            rd_d[1:0] = int_status_q;
         end else if (hit(haddr[11:0], `ADDR_IRQ_MASK)) begin
            rd_d[1:0] = int_mask_q;
         end else if (hit(haddr[11:0], `ADDR_BREAK_CTRL)) begin
            rd_d[0] = break_clear_enable_q;
         end else if (hit(haddr[11:0], `ADDR_PIN_LEVEL)) begin
            rd_d[0] = pin_level;
         end
      end
   end

   // data captured at address phase, shown during data phase;
   // a write in the data phase just before has not yet landed, so the old value is read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_d;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // reset masks every check except the one that guards reset itself
   a_edge_sets_latch: assert property (@(posedge clk_sys)
      disable iff (rst) pin_fall |=> req_latch_q)
      else $error("falling edge did not set latch");

   a_edge_mode_clear: assert property (@(posedge clk_sys)
      disable iff (rst)
      (!level_sense_select_q && ack_now && !pin_fall) |=> !req_latch_q)
      else $error("edge mode acknowledge did not clear");

   a_level_holds_low: assert property (@(posedge clk_sys)
      disable iff (rst)
      (level_sense_select_q && req_latch_q && !pin_level && !pin_fall)
      |=> req_latch_q)
      else $error("level mode latch cleared while pin low");

   a_mask_blocks_req: assert property (@(posedge clk_sys)
      disable iff (rst) ext_request_mask_q |=> !cpu_request)
      else $error("masked request reached cpu");

   // an acknowledge taken before break may still release a level latch
   a_break_protects: assert property (@(posedge clk_sys)
      disable iff (rst)
      (break_state && !break_clear_enable_q && !vector_fetch
       && req_latch_q && !ack_pending_q) |=> req_latch_q)
      else $error("latch cleared in protected break");

   a_sw_clear_works: assert property (@(posedge clk_sys)
      disable iff (rst)
      (latch_clear_strobe && !level_sense_select_q && !pin_fall)
      |=> !req_latch_q)
      else $error("software clear failed");

   a_flag_tracks: assert property (@(posedge clk_sys)
      disable iff (rst) live_req |=> cpu_request)
      else $error("request not forwarded");

   a_pin_reported: assert property (@(posedge clk_sys)
      disable iff (rst) branch_if_pin_high != branch_if_pin_low)
      else $error("pin level outputs disagree");

   a_irq_follows: assert property (@(posedge clk_sys)
      disable iff (rst)
      |(int_status_q & int_mask_q) |=> irq)
      else $error("interrupt output not raised");

   a_irq_drops: assert property (@(posedge clk_sys)
      disable iff (rst)
      !(|(int_status_q & int_mask_q)) |=> !irq)
      else $error("interrupt output stuck high");

   a_edge_status: assert property (@(posedge clk_sys)
      disable iff (rst) pin_fall |=> int_status_q[0])
      else $error("edge seen status not set");

   a_fetch_clears: assert property (@(posedge clk_sys)
      disable iff (rst)
      (vector_fetch && !level_sense_select_q && !pin_fall) |=> !req_latch_q)
      else $error("vector fetch did not clear latch");

   a_level_release: assert property (@(posedge clk_sys)
      disable iff (rst)
      (level_sense_select_q && (ack_now || ack_pending_q) && pin_level
       && !pin_fall) |=> !req_latch_q)
      else $error("level mode latch not released");

   a_reset_clears: assert property (@(posedge clk_sys)
      rst |=> (!req_latch_q && !cpu_request && !irq))
      else $error("reset left request state set");

   a_wake_follows: assert property (@(posedge clk_sys)
      disable iff (rst) (live_req && low_power) |=> wake_request)
      else $error("unmasked request did not wake");

   a_break_enabled_clear: assert property (@(posedge clk_sys)
      disable iff (rst)
      (break_state && break_clear_enable_q && latch_clear_strobe
       && !level_sense_select_q && !pin_fall) |=> !req_latch_q)
      else $error("enabled break clear did not clear");

   a_ctrl_readback: assert property (@(posedge clk_sys)
      disable iff (rst)
      (hready && hsel && htrans[1] && !hwrite
       && hit(haddr[11:0], `ADDR_STATUS_CONTROL))
      |=> (hrdata[7:4] == 4'h0 && !hrdata[`BIT_CLEAR]))
      else $error("reserved or clear bit read back nonzero");

   a_pin_low_seen: assert property (@(posedge clk_sys)
      disable iff (rst)
      !pin_level |=> (branch_if_pin_low && !branch_if_pin_high))
      else $error("low pin level not reported");

   // ------------------------------------------------------------
   // cover points
   // ------------------------------------------------------------
   c_edge_latch: cover property (@(posedge clk_sys) pin_fall ##1 req_latch_q);
   c_level_wait: cover property (@(posedge clk_sys)
      level_sense_select_q && ack_pending_q && !pin_level);
   c_break_clear: cover property (@(posedge clk_sys)
      break_state && latch_clear_strobe);
   c_wake_taken: cover property (@(posedge clk_sys) wake_request);
   c_fetch_level: cover property (@(posedge clk_sys)
      vector_fetch && level_sense_select_q && req_latch_q);
endmodule : ext_irq_latch

// ---- ext_irq_consts.svh ----
// constants for the external interrupt latch block
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
// word index of status/control; its byte address is four times it
`define IDX_STATUS_CONTROL  10'h03f
`define ADDR_STATUS_CONTROL {`IDX_STATUS_CONTROL, 2'b00}
`define ADDR_IRQ_STATUS     12'h040
`define ADDR_IRQ_MASK       12'h044
`define ADDR_BREAK_CTRL     12'h048
`define ADDR_PIN_LEVEL      12'h04c

// ---------------------------------------------------------------
// status and control fields
// ---------------------------------------------------------------
`define BIT_EVENT_FLAG 3
`define BIT_CLEAR      2
`define BIT_MASK       1
`define BIT_LEVEL_SEL  0
`define CTRL_RESET     8'h00

// ---------------------------------------------------------------
// vector address pair
// ---------------------------------------------------------------
`define VECTOR_HIGH 16'hfffa
`define VECTOR_LOW  16'hfffb

`endif

// ---- ext_irq_pkg.sv ----
// types for the external interrupt latch block
package ext_irq_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ
   } bus_phase_t;
endpackage : ext_irq_pkg

// ---- pin_sync.sv ----
// three-stage synchroniser with edge detect for the interrupt pin
`timescale 1ns/1ps
module pin_sync
   import ext_irq_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic pin_n,
   output logic      level_q,
   output logic      fall_q
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q  <= 1'b1;
         sync_q  <= 1'b1;
         level_q <= 1'b1;
      end else begin
         meta_q  <= pin_n;
         sync_q  <= meta_q;
         level_q <= sync_q;
      end
   end

   // the second and third stages (sync_q, level_q) feed the edge compare
   always_ff @(posedge clk_sys) begin
      if (rst) fall_q <= 1'b0;
      else     fall_q <= level_q & ~sync_q;
   end
endmodule : pin_sync

// ---- irq_source.sv ----
// model of the external source driving the interrupt pin
`timescale 1ns/1ps
module irq_source (
   input  wire logic clk_sys,
   output logic      pin_n
);
   initial pin_n = 1'b1;

   // off-edge change: the pin is asynchronous to clk_sys
   task automatic drive(input logic lvl);
      @(posedge clk_sys);
      #1.7 pin_n = lvl;
      // hold long enough for the synchroniser to take the level
      repeat (4) @(posedge clk_sys);
   endtask : drive
endmodule : irq_source

// ---- tb_top.sv ----
// self-checking testbench for the external interrupt latch
`timescale 1ns/1ps
`include "ext_irq_consts.svh"
module tb_top;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        vector_fetch = 1'b0;
   logic        break_state = 1'b0;
   logic        low_power = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [15:0] vector_addr;
   logic        hreadyout, hresp, cpu_request, wake_request, irq;
   logic        branch_if_pin_high, branch_if_pin_low, pin_n;
   logic [31:0] d;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc = 0;
   localparam logic [11:0] sc_addr = `ADDR_STATUS_CONTROL;

   always #2.5 clk_sys = ~clk_sys;

   irq_source src_u (.clk_sys(clk_sys), .pin_n(pin_n));

   ext_irq_latch dut_u (
      .clk_sys(clk_sys), .rst(rst), .irq_pin_n(pin_n),
      .vector_fetch(vector_fetch), .break_state(break_state),
      .low_power(low_power), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .cpu_request(cpu_request), .wake_request(wake_request),
      .vector_addr(vector_addr),
      .branch_if_pin_high(branch_if_pin_high),
      .branch_if_pin_low(branch_if_pin_low), .irq(irq)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic logic [31:0] ctrl(input logic f, m, s);
      return {28'h0, f, 1'b0, m, s};
   endfunction : ctrl

   // address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] r;
      bus(1'b1, a, wd, r);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask : rdc

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic pin(input logic lvl);
      src_u.drive(lvl);
      tick(4);
   endtask : pin

   task automatic fetch();
      vector_fetch <= 1'b1;
      tick(1);
      vector_fetch <= 1'b0;
      tick(2);
   endtask : fetch

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(41931));
      tick(20);
      rst <= 1'b0;
      tick(1);
      rdc(sc_addr, 32'h0);
      check({hreadyout, hresp}, 2'b10);
      check(vector_addr, `VECTOR_HIGH);
      check(branch_if_pin_high, 1'b1);
      wr(12'h044, 32'h1);
      pin(1'b0);
      rdc(sc_addr, ctrl(1, 0, 0));
      check(cpu_request, 1'b1);
      check(irq, 1'b1);
      check({branch_if_pin_high, branch_if_pin_low}, 2'b01);
      wr(12'h040, 32'h1);
      tick(2);
      check(irq, 1'b0);
      wr(sc_addr, 32'h4);
      tick(2);
      rdc(sc_addr, 32'h0);
      check(cpu_request, 1'b0);
      pin(1'b1);
      pin(1'b0);
      rdc(sc_addr, ctrl(1, 0, 0));
      fetch();
      rdc(sc_addr, 32'h0);
      pin(1'b1);
      wr(sc_addr, 32'h2);
      pin(1'b0);
      rdc(sc_addr, ctrl(1, 1, 0));
      check(cpu_request, 1'b0);
      low_power <= 1'b1;
      wr(sc_addr, 32'h0);
      tick(3);
      check(wake_request, 1'b1);
      low_power <= 1'b0;
      wr(sc_addr, 32'h4);
      pin(1'b1);
      // level mode: the service routine masks while it clears
      wr(sc_addr, 32'h1);
      pin(1'b0);
      wr(sc_addr, 32'h7);
      tick(2);
      rdc(sc_addr, ctrl(1, 1, 1));
      check(cpu_request, 1'b0);
      pin(1'b1);
      rdc(sc_addr, ctrl(0, 1, 1));
      wr(sc_addr, 32'h1);
      pin(1'b0);
      pin(1'b1);
      rdc(sc_addr, ctrl(1, 0, 1));
      fetch();
      rdc(sc_addr, ctrl(0, 0, 1));
      // break with the clear enable off, then on
      wr(sc_addr, 32'h0);
      wr(12'h048, 32'h0);
      pin(1'b0);
      break_state <= 1'b1;
      wr(sc_addr, 32'h4);
      tick(2);
      rdc(sc_addr, ctrl(1, 0, 0));
      wr(12'h048, 32'h1);
      wr(sc_addr, 32'h4);
      tick(2);
      break_state <= 1'b0;
      tick(2);
      rdc(sc_addr, 32'h0);
      pin(1'b1);
      rdc(12'h080, 32'h0);
      repeat (8) begin
         d = $urandom & 32'h3;
         wr(sc_addr, d);
         rdc(sc_addr, ctrl(0, d[1], d[0]));
      end
      wr(sc_addr, 32'h0);
      pin(1'b0);
      pin(1'b1);
      rst <= 1'b1;
      tick(4);
      rst <= 1'b0;
      tick(1);
      rdc(sc_addr, 32'h0);
      check(cpu_request, 1'b0);
      rdc(12'h04c, 32'h1);
      test_done();
   end
endmodule : tb_top
